// ---- dv/fts_roller_model.sv ----
// Roller and thermistor model facing the heater outputs
`timescale 1ns/1ps
module fts_roller_model (
    // Clock
    input wire logic clk,
    // Lamps and bench setpoints
    input wire logic heat_c,
    input wire logic heat_s,
    input wire logic warm,
    input wire logic [7:0] set_c,
    input wire logic [7:0] set_s,
    input wire logic [7:0] set_e,
    // Thermistor readings
    output logic [7:0] t_c,
    output logic [7:0] t_s,
    output logic [7:0] t_e
);
    // With warm set, heated zones climb one degree a cycle up to 200C while lit and hold when unlit; without warm, follow setpoints
    always_ff @(posedge clk) begin
        t_e <= set_e;
        t_c <= (!warm) ? set_c : (heat_c && t_c < 8'hC8) ? t_c + 8'h01 : t_c;
        t_s <= (!warm) ? set_s : (heat_s && t_s < 8'hC8) ? t_s + 8'h01 : t_s;
    end
endmodule

// ---- dv/fuser_temp_supervisor_tb.sv ----
// Self-checking bench for the fuser temperature supervisor
`timescale 1ns/1ps
module fuser_temp_supervisor_tb import fts_pkg::*;;
    logic clk = 0, rst_n = 0, warm = 0, print_req = 0, print_done = 0, reg_wr = 0, reg_rd = 0;
    logic [7:0] tc = 8'h19, ts = 8'h19, te = 8'h19, t_c, t_s, t_e, reg_wdata = 8'h00, reg_rdata;
    logic [3:0] nv = 4'h0, reg_addr = 4'h0, nv_wdata, fault_cnt, n;
    logic nv_wr, heat_center, heat_side, outputs_off, power_off, ready, printing, deep_sleep;
    logic [2:0] fault_code;
    logic [7:0] d;
    logic seen_low;
    int fail_count = 0, n_checks = 0;
    ////////////////////////////////////////////////////////////////////////
    always #12.5 clk = ~clk;
    fts_supervisor #(.TICK_CYC(4), .WARM40_S(8'h40), .WARM100_S(8'h40)) dut (
        .clk(clk), .rst_n(rst_n), .temp_center(t_c), .temp_side(t_s), .temp_edge(t_e),
        .print_req(print_req), .print_done(print_done), .nv_rdata(nv), .nv_wr(nv_wr),
        .nv_wdata(nv_wdata), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .heat_center(heat_center),
        .heat_side(heat_side), .outputs_off(outputs_off), .power_off(power_off),
        .ready(ready), .printing(printing), .deep_sleep(deep_sleep),
        .fault_code(fault_code), .fault_cnt(fault_cnt));
    fts_roller_model rm (.clk(clk), .heat_c(heat_center), .heat_s(heat_side), .warm(warm),
        .set_c(tc), .set_s(ts), .set_e(te), .t_c(t_c), .t_s(t_s), .t_e(t_e));
    ////////////////////////////////////////////////////////////////////////
    // Compare and count
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task test_done;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task rst(input logic [3:0] v, input logic [7:0] c, s, e, input logic w);
        nv <= v; tc <= c; ts <= s; te <= e; warm <= w; rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
    endtask
    task wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk) begin reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= v; end
        @(posedge clk) reg_wr <= 1'b0;
    endtask
    task rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge clk) begin reg_rd <= 1'b1; reg_addr <= a; end
        @(posedge clk) reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask
    // Poll the state field of STATUS, noting any pass through low energy
    task wait_st(input logic [3:0] s);
        int i;
        for (i = 0; i < 3000; i++) begin
            rd(A_STATUS, d);
            if (d[3:0] == 4'h6) seen_low = 1'b1;
            if (d[3:0] == s) break;
        end
        chk(d[3:0], s);
    endtask
    task pulse(input logic done);
        @(posedge clk) if (done) print_done <= 1'b1; else print_req <= 1'b1;
        @(posedge clk) begin print_done <= 1'b0; print_req <= 1'b0; end
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Watchdog
    initial begin
        #(25 * 100000);
        fail_count++;
        test_done;
    end
    initial begin
        void'($urandom(81));
        n = 4'(2 + $urandom % 8);
        rst(n, 8'h19, 8'h19, 8'h19, 0);
        repeat (8) @(posedge clk);
        chk(fault_code, 1); chk(fault_cnt, n); chk(heat_center, 0);
        $display("lockout test done");
        rst(0, 8'hF5, 8'h64, 8'h64, 0);
        repeat (8) @(posedge clk);
        chk(fault_code, 3); chk(nv_wdata, 9);
        chk({outputs_off, power_off}, 2'b11);
        $display("overheat test done");
        rst(0, 8'h1E, 8'h1E, 8'h3C, 0); wait_st(ST_FAULT);
        chk(fault_code, 1); chk(fault_cnt, 1);
        rst(0, 8'h3C, 8'h3C, 8'h3C, 0); wait_st(ST_FAULT);
        chk(fault_code, 3); chk(fault_cnt, 5);
        rst(0, 8'h3C, 8'h3C, 8'h3C, 0); wait_st(ST_WARM100);
        tc <= 8'h1E; ts <= 8'hA0; wait_st(ST_FAULT);
        chk(fault_code, 2); chk(fault_cnt, 4);
        $display("warm-up fault tests done");
        rst(1, 8'h3C, 8'h3C, 8'h3C, 1); wait_st(ST_READY);
        chk(fault_cnt, 0); chk(ready, 1);
        wr(A_FCNT, 8'h0A); rd(A_FCNT, d); chk(d, 0);
        wr(A_FCNT, 8'h03); rd(A_FCNT, d); chk(d, 3);
        wr(A_FCNT, 8'h00); #1 chk(nv_wr, 1); chk(nv_wdata, 0);
        rd(4'hF, d); chk(d, 0);
        warm <= 0; tc <= 8'h96; ts <= 8'h96; repeat (6) @(posedge clk);
        chk(heat_center, 1);
        te <= 8'hEB; repeat (6) @(posedge clk); chk({heat_center, heat_side}, 0);
        te <= 8'h3C; tc <= 8'h00; repeat (6) @(posedge clk); chk(heat_center, 0);
        tc <= 8'hB4; ts <= 8'hB4;
        $display("ready tests done");
        wr(A_LOW_TMO, 8'h01); wr(A_OFF_TMO, 8'h0A);
        pulse(0); wait_st(ST_PRINT); pulse(1);
        wait_st(ST_LOW_ENERGY); wait_st(ST_SHUT_OFF); chk(deep_sleep, 0);
        pulse(0); wait_st(ST_PRINT); chk(printing, 1);
        wr(A_LOW_TMO, 8'h02); wr(A_OFF_TMO, 8'h02); wr(A_CTRL, 8'h01);
        seen_low = 0; pulse(1); wait_st(ST_SHUT_OFF);
        chk(seen_low, 0); chk(deep_sleep, 1);
        pulse(0); wait_st(ST_PRINT);
        te <= 8'h1E; wait_st(ST_FAULT); chk(fault_code, 4); chk(fault_cnt, 6);
        $display("energy and print tests done");
        test_done;
    end
endmodule

// ---- logic/fts_idle_timer.sv ----
// Idle timer that expires after a programmed number of ticks
`timescale 1ns/1ps
module fts_idle_timer import fts_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Control
    input wire logic tick,
    input wire logic restart,
    input wire logic cancel,
    input wire logic [7:0] limit,
    // Status
    output logic expired
);
    typedef struct packed {
        logic [7:0] cnt;
        logic run;
        logic exp;
    } fts_tmr_s;

    fts_tmr_s q;
    fts_tmr_s d;

    // Cancel beats restart; count ticks while running
    always_comb begin
        d = q;
        if (cancel) begin
            d = '0;
        end else if (restart) begin
            d.cnt = 8'h00;
            d.run = 1'b1;
            d.exp = 1'b0;
        end else if (q.run && tick) begin
            if (q.cnt + 8'h01 >= limit) begin
                d.run = 1'b0;
                d.exp = 1'b1;
            end else begin
                d.cnt = q.cnt + 8'h01;
            end
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign expired = q.exp;

    AST_TMR_CANCEL: assert property (@(posedge clk) disable iff (!rst_n)
        cancel |=> !expired) else $error("timer expired after cancel");
endmodule

// ---- logic/fts_pkg.sv ----
// Shared constants and types for the fuser temperature supervisor
package fts_pkg;
    // Clock and time base
    localparam int CLK_HZ = 40_000_000;
    localparam int TICK_PERIOD_S = 1;
    localparam int TICK_CYCLES = CLK_HZ * TICK_PERIOD_S;
    localparam int IDLE_DEF_MIN = 1;
    localparam logic [7:0] IDLE_DEF_S = 8'(IDLE_DEF_MIN * 60);
    localparam logic [7:0] WARM40_DEF_S = 8'h1E;
    localparam logic [7:0] WARM100_DEF_S = 8'h3C;
    localparam int PO_SETTLE = 3;

    // Temperature thresholds in degrees C
    localparam logic [7:0] T_EDGE_ABN = 8'hE6;
    localparam logic [7:0] T_OVERHEAT = 8'hF0;
    localparam logic [7:0] T_LOW = 8'h28;
    localparam logic [7:0] T_MID = 8'h64;
    localparam logic [7:0] T_HIGH = 8'h96;
    localparam logic [7:0] T_READY = 8'hB4;
    localparam logic [7:0] T_SAVE = 8'h78;
    localparam logic [7:0] T_BREAK = 8'h00;

    // Fault counter values
    localparam logic [3:0] CNT_ZERO = 4'h0;
    localparam logic [3:0] CNT_LOW1 = 4'h1;
    localparam logic [3:0] CNT_LOW2 = 4'h2;
    localparam logic [3:0] CNT_DISC = 4'h4;
    localparam logic [3:0] CNT_HEAT = 4'h5;
    localparam logic [3:0] CNT_EDGE = 4'h6;
    localparam logic [3:0] CNT_OVERHEAT = 4'h9;
    localparam logic [3:0] CNT_MAX = 4'h9;

    // Register offsets and fields
    localparam logic [3:0] A_CTRL = 4'h0;
    localparam logic [3:0] A_LOW_TMO = 4'h1;
    localparam logic [3:0] A_OFF_TMO = 4'h2;
    localparam logic [3:0] A_FCNT = 4'h3;
    localparam logic [3:0] A_STATUS = 4'h4;
    localparam int CTRL_SSLEEP_BIT = 0;
    localparam logic CTRL_SSLEEP_RST = 1'b0;

    typedef enum logic [2:0] {
        NO_FAULT_CODE,
        LOW_TEMP_FAULT_CODE,
        SENSOR_DISCONNECT_FAULT_CODE,
        OVERHEAT_HEATING_FAULT_CODE,
        EDGE_LOW_TEMP_FAULT_CODE
    } fts_fault_e;

    typedef enum logic [3:0] {
        ST_POWER_ON,
        ST_WARM40,
        ST_WARM100,
        ST_WARM_RDY,
        ST_READY,
        ST_PRINT,
        ST_LOW_ENERGY,
        ST_SHUT_OFF,
        ST_FAULT,
        ST_OH_SAVE,
        ST_OH_OUTS,
        ST_POWER_OFF
    } fts_state_e;
endpackage

// ---- logic/fts_supervisor.sv ----
// Fuser temperature supervisor: stages, fault checks, energy saving
////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - Edge at 230C or more cuts heaters
// - Idle low-energy timeout lowers regulation setpoint
// - Idle shut-off timeout keeps heaters off
// - Equal timeouts choose shut-off over low-energy
// - Print request in saving rewarms to ready
// - Setting enables deep sleep in shut-off
// - Counter two or more locks heater at power-on
// - Normal ready with counter at most one clears it
// - Counter only ever holds zero to nine
// - Overheat saves nine, cuts outputs, removes power
// - Still hot at power-on powers off again
// - Broken thermistor stops heating
// - Center or side 240C raises overheat first
// - Still cold at first stage timeout: low fault
// - Cold beside hot sensor raises disconnect fault
// - At or below 100C at second timeout: heating fault
// - Checks run in priority order per stage
// - Edge cold while printing raises edge fault
////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
module fts_supervisor import fts_pkg::*; #(
    parameter int TICK_CYC = TICK_CYCLES,
    parameter logic [7:0] WARM40_S = WARM40_DEF_S,
    parameter logic [7:0] WARM100_S = WARM100_DEF_S
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Thermistor readings in degrees C, from the converter
    input wire logic [7:0] temp_center,
    input wire logic [7:0] temp_side,
    input wire logic [7:0] temp_edge,
    // Engine controller
    input wire logic print_req,
    input wire logic print_done,
    // Nonvolatile fault counter storage
    input wire logic [3:0] nv_rdata,
    output logic nv_wr,
    output logic [3:0] nv_wdata,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Heater and power control
    output logic heat_center,
    output logic heat_side,
    output logic outputs_off,
    output logic power_off,
    // Status
    output logic ready,
    output logic printing,
    output logic deep_sleep,
    output logic [2:0] fault_code,
    output logic [3:0] fault_cnt
);
    typedef struct packed {
        logic [7:0] tc1;
        logic [7:0] ts1;
        logic [7:0] te1;
        logic [7:0] tc;
        logic [7:0] ts;
        logic [7:0] te;
        fts_state_e st;
        logic [7:0] stage_s;
        logic [1:0] po_cnt;
        logic [3:0] fcnt;
        fts_fault_e fcode;
        logic pend;
        logic ssleep_en;
        logic [7:0] low_tmo;
        logic [7:0] off_tmo;
        logic brk;
        logic tmr_rst;
        logic nv_wr;
        logic heat_c;
        logic heat_s;
        logic outs_off;
        logic pwr_off;
        logic ready;
        logic printing;
        logic deep;
        logic [7:0] rdata;
    } fts_main_s;

    fts_main_s q;
    fts_main_s d;

    logic tick;
    logic low_exp;
    logic off_exp;
    logic ovh_cs;
    logic ovh_e;
    logic lo_c;
    logic lo_s;
    logic lo_e;
    logic hi_c;
    logic hi_s;
    logic hi_e;
    logic mid_c;
    logic mid_s;
    logic edge_abn;
    logic brk_any;
    logic disc_cs;
    logic disc_se;
    logic f_hit;
    logic f_oh;
    fts_fault_e f_code;
    logic [3:0] f_cnt;
    logic regulating;
    logic [7:0] setpoint;

    ////////////////////////////////////////////////////////////////////
    // Time base and idle timers
    fts_tick_div #(.CYCLES(TICK_CYC)) u_div (
        .clk(clk),
        .rst_n(rst_n),
        .tick(tick)
    );

    fts_idle_timer u_low_tmr (
        .clk(clk),
        .rst_n(rst_n),
        .tick(tick),
        .restart(q.tmr_rst),
        .cancel(print_req),
        .limit(q.low_tmo),
        .expired(low_exp)
    );

    fts_idle_timer u_off_tmr (
        .clk(clk),
        .rst_n(rst_n),
        .tick(tick),
        .restart(q.tmr_rst),
        .cancel(print_req),
        .limit(q.off_tmo),
        .expired(off_exp)
    );

    ////////////////////////////////////////////////////////////////////
    // Threshold comparisons on the synchronised readings
    assign ovh_cs = (q.tc >= T_OVERHEAT) || (q.ts >= T_OVERHEAT);
    assign ovh_e = q.te >= T_OVERHEAT;
    assign lo_c = q.tc <= T_LOW;
    assign lo_s = q.ts <= T_LOW;
    assign lo_e = q.te <= T_LOW;
    assign hi_c = q.tc >= T_HIGH;
    assign hi_s = q.ts >= T_HIGH;
    assign hi_e = q.te >= T_HIGH;
    assign mid_c = q.tc <= T_MID;
    assign mid_s = q.ts <= T_MID;
    assign edge_abn = q.te >= T_EDGE_ABN;
    assign brk_any = (q.tc == T_BREAK) || (q.ts == T_BREAK) || (q.te == T_BREAK);
    assign disc_cs = (lo_c && hi_s) || (hi_c && lo_s);
    assign disc_se = (lo_s && hi_e) || (hi_s && lo_e);
    assign regulating = (q.st inside {ST_WARM40, ST_WARM100, ST_WARM_RDY, ST_READY,
                                      ST_PRINT, ST_LOW_ENERGY});
    assign setpoint = (q.st == ST_LOW_ENERGY) ? T_SAVE : T_READY;

    ////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        d = q;
        f_hit = 1'b0;
        f_oh = 1'b0;
        f_code = NO_FAULT_CODE;
        f_cnt = q.fcnt;
        d.tc1 = temp_center;
        d.ts1 = temp_side;
        d.te1 = temp_edge;
        d.tc = q.tc1;
        d.ts = q.ts1;
        d.te = q.te1;
        d.nv_wr = 1'b0;
        d.tmr_rst = 1'b0;
        d.rdata = 8'h00;
        if (tick && (q.stage_s != 8'hFF)) begin
            d.stage_s = q.stage_s + 8'h01;
        end
        // Overheat is the first check in every active stage
        if (q.st inside {ST_WARM40, ST_WARM100, ST_WARM_RDY, ST_READY,
                         ST_LOW_ENERGY, ST_SHUT_OFF}) begin
            if (ovh_cs) begin
                f_hit = 1'b1;
                f_oh = 1'b1;
            end
        end
        case (q.st)
            ST_POWER_ON: begin
                // Let the synchronisers fill before judging
                d.fcnt = (nv_rdata > CNT_MAX) ? CNT_MAX : nv_rdata;
                if (q.po_cnt != 2'(PO_SETTLE)) begin
                    d.po_cnt = q.po_cnt + 2'h1;
                end else if (ovh_cs) begin
                    f_hit = 1'b1;
                    f_oh = 1'b1;
                end else if (q.fcnt >= CNT_LOW2) begin
                    d.st = ST_FAULT;
                    d.fcode = LOW_TEMP_FAULT_CODE;
                end else begin
                    d.st = ST_WARM40;
                end
            end
            ST_WARM40: begin
                if (!f_hit) begin
                    if (!lo_c && !lo_s) begin
                        d.st = ST_WARM100;
                    end else if (q.stage_s >= WARM40_S) begin
                        f_hit = 1'b1;
                        f_code = LOW_TEMP_FAULT_CODE;
                        f_cnt = (q.fcnt >= CNT_LOW1) ? CNT_LOW2 : CNT_LOW1;
                    end
                end
            end
            ST_WARM100: begin
                if (!f_hit) begin
                    if (disc_cs) begin
                        f_hit = 1'b1;
                        f_code = SENSOR_DISCONNECT_FAULT_CODE;
                        f_cnt = CNT_DISC;
                    end else if (!mid_c && !mid_s) begin
                        d.st = ST_WARM_RDY;
                    end else if (q.stage_s >= WARM100_S) begin
                        f_hit = 1'b1;
                        f_code = OVERHEAT_HEATING_FAULT_CODE;
                        f_cnt = CNT_HEAT;
                    end
                end
            end
            ST_WARM_RDY: begin
                if (!f_hit) begin
                    if (disc_cs || disc_se) begin
                        f_hit = 1'b1;
                        f_code = SENSOR_DISCONNECT_FAULT_CODE;
                        f_cnt = CNT_DISC;
                    end else if ((q.tc >= T_READY) && (q.ts >= T_READY)) begin
                        d.st = ST_READY;
                        d.tmr_rst = 1'b1;
                        if ((q.fcnt <= CNT_LOW1) && (q.fcnt != CNT_ZERO)) begin
                            d.fcnt = CNT_ZERO;
                            d.nv_wr = 1'b1;
                        end
                    end
                end
            end
            ST_READY: begin
                if (!f_hit) begin
                    if (print_req || q.pend) begin
                        d.st = ST_PRINT;
                        d.pend = 1'b0;
                    end else if (off_exp && !q.tmr_rst) begin
                        d.st = ST_SHUT_OFF;
                    end else if (low_exp && !q.tmr_rst) begin
                        d.st = ST_LOW_ENERGY;
                    end
                end
            end
            ST_PRINT: begin
                // Edge is also watched for overheat while paper runs
                if (ovh_cs || ovh_e) begin
                    f_hit = 1'b1;
                    f_oh = 1'b1;
                end else if (lo_e) begin
                    f_hit = 1'b1;
                    f_code = EDGE_LOW_TEMP_FAULT_CODE;
                    f_cnt = CNT_EDGE;
                end else if (print_done) begin
                    d.st = ST_READY;
                    d.tmr_rst = 1'b1;
                end
            end
            ST_LOW_ENERGY: begin
                if (!f_hit) begin
                    if (print_req) begin
                        d.st = ST_WARM_RDY;
                        d.pend = 1'b1;
                    end else if (off_exp) begin
                        d.st = ST_SHUT_OFF;
                    end
                end
            end
            ST_SHUT_OFF: begin
                if (!f_hit && print_req) begin
                    d.st = ST_WARM_RDY;
                    d.pend = 1'b1;
                end
            end
            ST_OH_SAVE: begin
                d.st = ST_OH_OUTS;
                d.outs_off = 1'b1;
            end
            ST_OH_OUTS: begin
                d.st = ST_POWER_OFF;
                d.pwr_off = 1'b1;
            end
            ST_FAULT: begin
                d.st = ST_FAULT;
            end
            ST_POWER_OFF: begin
                d.st = ST_POWER_OFF;
            end
            default: begin
                d.st = ST_FAULT;
            end
        endcase
        // Software settings; a counter write above nine is dropped
        if (reg_wr) begin
            case (reg_addr)
                A_CTRL: d.ssleep_en = reg_wdata[CTRL_SSLEEP_BIT];
                A_LOW_TMO: d.low_tmo = reg_wdata;
                A_OFF_TMO: d.off_tmo = reg_wdata;
                A_FCNT: begin
                    if (reg_wdata <= {4'h0, CNT_MAX}) begin
                        d.fcnt = reg_wdata[3:0];
                        d.nv_wr = 1'b1;
                    end
                end
                default: d.rdata = 8'h00;
            endcase
        end
        // Fault entry overrides any write to the counter
        if (f_hit) begin
            d.pend = 1'b0;
            d.nv_wr = 1'b1;
            if (f_oh) begin
                d.st = ST_OH_SAVE;
                d.fcode = OVERHEAT_HEATING_FAULT_CODE;
                d.fcnt = CNT_OVERHEAT;
            end else begin
                d.st = ST_FAULT;
                d.fcode = f_code;
                d.fcnt = f_cnt;
            end
        end
        // Register reads, answered in the next cycle
        if (reg_rd) begin
            case (reg_addr)
                A_CTRL: d.rdata = {7'h00, q.ssleep_en};
                A_LOW_TMO: d.rdata = q.low_tmo;
                A_OFF_TMO: d.rdata = q.off_tmo;
                A_FCNT: d.rdata = {4'h0, q.fcnt};
                A_STATUS: d.rdata = {q.brk, q.fcode, q.st};
                default: d.rdata = 8'h00;
            endcase
        end
        if (d.st != q.st) begin
            d.stage_s = 8'h00;
        end
        // Heater drive and status outputs
        d.brk = brk_any && (q.st != ST_POWER_ON);
        d.heat_c = regulating && !d.brk && !edge_abn && !f_hit && (q.tc < setpoint);
        d.heat_s = regulating && !d.brk && !edge_abn && !f_hit && (q.ts < setpoint);
        d.ready = (q.st == ST_READY) || (q.st == ST_PRINT);
        d.printing = q.st == ST_PRINT;
        d.deep = (q.st == ST_SHUT_OFF) && q.ssleep_en;
    end

    ////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            q <= '0;
            q.st <= ST_POWER_ON;
            q.fcode <= NO_FAULT_CODE;
            q.ssleep_en <= CTRL_SSLEEP_RST;
            q.low_tmo <= IDLE_DEF_S;
            q.off_tmo <= IDLE_DEF_S;
        end else begin
            q <= d;
        end
    end

    // Outputs straight from the state register
    assign nv_wr = q.nv_wr;
    assign nv_wdata = q.fcnt;
    assign reg_rdata = q.rdata;
    assign heat_center = q.heat_c;
    assign heat_side = q.heat_s;
    assign outputs_off = q.outs_off;
    assign power_off = q.pwr_off;
    assign ready = q.ready;
    assign printing = q.printing;
    assign deep_sleep = q.deep;
    assign fault_code = q.fcode;
    assign fault_cnt = q.fcnt;

    ////////////////////////////////////////////////////////////////////
    // Checks
    AST_EDGE_CUT: assert property (@(posedge clk) disable iff (!rst_n)
        edge_abn |=> !heat_center && !heat_side) else $error("heater on with hot edge");
    AST_LOW_ENERGY: assert property (@(posedge clk) disable iff (!rst_n)
        q.st == ST_READY && !q.tmr_rst && low_exp && !off_exp && !print_req && !q.pend
        && !ovh_cs |=> q.st == ST_LOW_ENERGY) else $error("low energy not entered");
    AST_SHUT_HEAT: assert property (@(posedge clk) disable iff (!rst_n)
        $past(q.st) == ST_SHUT_OFF |-> !heat_center && !heat_side)
        else $error("heater on in shut-off");
    AST_EQUAL_TMO: assert property (@(posedge clk) disable iff (!rst_n)
        q.st == ST_READY && !q.tmr_rst && off_exp && low_exp && !print_req && !q.pend
        && !ovh_cs |=> q.st == ST_SHUT_OFF) else $error("shut-off lost priority");
    AST_WAKE: assert property (@(posedge clk) disable iff (!rst_n)
        q.st inside {ST_LOW_ENERGY, ST_SHUT_OFF} && print_req && !ovh_cs
        |=> q.st == ST_WARM_RDY && q.pend) else $error("saving state not left");
    AST_DEEP: assert property (@(posedge clk) disable iff (!rst_n)
        $past(q.st) == ST_SHUT_OFF && $past(q.ssleep_en) |-> deep_sleep)
        else $error("deep sleep missing");
    AST_LOCKOUT: assert property (@(posedge clk) disable iff (!rst_n)
        q.st == ST_POWER_ON && q.po_cnt == 2'(PO_SETTLE) && !ovh_cs && q.fcnt >= CNT_LOW2
        |=> q.st == ST_FAULT && fault_code == LOW_TEMP_FAULT_CODE ##1 !heat_center)
        else $error("lockout not applied");
    AST_READY_CLR: assert property (@(posedge clk) disable iff (!rst_n)
        (q.st == ST_WARM_RDY && q.fcnt <= CNT_LOW1) ##1 q.st == ST_READY |-> q.fcnt == CNT_ZERO)
        else $error("counter not cleared at ready");
    AST_CNT_RANGE: assert property (@(posedge clk) disable iff (!rst_n)
        fault_cnt <= CNT_MAX) else $error("counter out of range");
    AST_OH_SEQ: assert property (@(posedge clk) disable iff (!rst_n)
        q.st == ST_OH_SAVE |-> nv_wr && fault_cnt == CNT_OVERHEAT && !outputs_off
        ##1 outputs_off && !power_off ##1 power_off) else $error("overheat sequence wrong");
    AST_BREAK: assert property (@(posedge clk) disable iff (!rst_n)
        q.brk |-> !heat_center && !heat_side) else $error("heating on broken sensor");

    COV_LOW: cover property (@(posedge clk) disable iff (!rst_n) q.st == ST_LOW_ENERGY);
    COV_SHUT: cover property (@(posedge clk) disable iff (!rst_n) deep_sleep);
    COV_PRINT: cover property (@(posedge clk) disable iff (!rst_n) printing ##1 !printing);
    COV_OFF: cover property (@(posedge clk) disable iff (!rst_n) power_off);
endmodule

// ---- logic/fts_tick_div.sv ----
// Divider that makes a one-cycle tick every CYCLES clocks
`timescale 1ns/1ps
module fts_tick_div import fts_pkg::*; #(
    parameter int CYCLES = TICK_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Tick out
    output logic tick
);
    localparam int W = (CYCLES > 1) ? $clog2(CYCLES) : 1;
    localparam logic [W-1:0] LAST = W'(CYCLES - 1);

    typedef struct packed {
        logic [W-1:0] cnt;
        logic tick;
    } fts_div_s;

    fts_div_s q;
    fts_div_s d;

    // Count up one period and pulse at its end
    always_comb begin
        d = q;
        d.tick = 1'b0;
        if (q.cnt == LAST) begin
            d.cnt = '0;
            d.tick = 1'b1;
        end else begin
            d.cnt = q.cnt + W'(1);
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign tick = q.tick;

    AST_TICK_SPACING: assert property (@(posedge clk) disable iff (!rst_n)
        tick |=> !tick or (CYCLES == 1)) else $error("tick pulses back to back");
endmodule
